// >>> common/pic_params.svh
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PIC_IDX_CTRL      8'h00
`define PIC_IDX_STATUS    8'h01
`define PIC_IDX_NMICFG    8'h02
`define PIC_IDX_NMI_FLAG_REG   8'h03
`define PIC_IDX_EVOUT     8'h04
`define PIC_IDX_INTENCLR  8'h05
`define PIC_IDX_INTENSET  8'h06
`define PIC_IDX_IRQFLAG   8'h07
`define PIC_IDX_WAKE      8'h08
`define PIC_IDX_SENSE     8'h09

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PIC_CTRL_SOFT_RESET_BIT    0
`define PIC_CTRL_ENABLE   1
`define PIC_STAT_BUSY     7
`define PIC_NMI_FILT      3

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define PIC_RST_BYTE      8'h00
`define PIC_RST_SENSE     32'h0000_0000
`define PIC_SYNC_CYC      2'h3
`define PIC_NUM_PINS      8

`endif

// >>> common/pic_pkg.sv
// ----------------------------------------------------------------------------
// shared types of the pin interrupt controller
// ----------------------------------------------------------------------------
package pic_pkg;

	// detection sense encodings
	typedef enum logic [2:0] {
		PIC_SENSE_NONE = 3'h0,
		PIC_SENSE_RISE = 3'h1,
		PIC_SENSE_FALL = 3'h2,
		PIC_SENSE_BOTH = 3'h3,
		PIC_SENSE_HIGH = 3'h4,
		PIC_SENSE_LOW  = 3'h5
	} pic_sense_t;

	// one pin's configuration nibble
	typedef struct packed {
		logic       filt_en; // majority filter on
		logic [2:0] sense;   // detection sense
	} pic_pin_cfg_t;

	// bus-side state of the control sync path
	typedef enum logic [1:0] {
		PIC_SYNC_IDLE,
		PIC_SYNC_RUN
	} pic_sync_t;

endpackage : pic_pkg

// >>> design/pic_pin_irq_controller.sv
// Operation
// - eight external inputs plus one nmi input
// - independent mask per external line
// - rise, fall, both, high, low sense
// - spike filter switchable per pin
// - filter is majority vote on detection clock
// - level detection needs no filter clock
// - events leave as single-cycle pulses
// - nmi drives the processor nmi request
// - one shared request plus one nmi request
// - debug halt does not stop detection
// - protection guards all writes except flags
// - debugger writes bypass write protection
// - keeps running and wakes while clocked
// - wake enable masks chosen wake sources
// - control writes pass a synchronising delay
// - writing enable one enables controller
// - writing enable zero disables controller
// - soft reset restores all registers, disabled
// - filter votes two of three samples
// - level re-flags at once; edge needs edge
// - busy bit set at once; stalls control writes
// - nmi sense resets to no detection
`include "pic_params.svh"

module pic_pin_irq_controller
	import pic_pkg::*;
(
	input  wire logic        ref_clk_i,     // system clock
	input  wire logic        sys_rst_i,     // synchronous reset, high
	input  wire logic        psel_i,        // apb select
	input  wire logic        penable_i,     // apb enable
	input  wire logic        pwrite_i,      // apb direction
	input  wire logic [31:0] paddr_i,       // apb byte address
	input  wire logic [31:0] pwdata_i,      // apb write data
	output logic      [31:0] prdata_o,      // apb read data
	output logic             pready_o,      // apb ready
	output logic             pslverr_o,     // apb error
	input  wire logic        wr_protect_i,  // access protector lock
	input  wire logic        dbg_access_i,  // access from debugger
	input  wire logic [7:0]  ext_irq_input_i, // external pins
	input  wire logic        nmi_i,         // non-maskable pin
	output logic             irq_o,         // shared request
	output logic             nmi_req_o,     // nmi request
	output logic [7:0]       event_o,       // event pulses
	output logic             wake_o         // sleep wake request
);

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	logic                  enable;       // controller enabled
	logic [2:0]            nmi_sense;    // nmi sense
	logic                  nmi_filt;     // nmi filter on
	logic                  nmi_flag;     // nmi flag
	logic [7:0]            event_out;    // event enables
	logic [7:0]            irq_en;       // interrupt masks
	logic [7:0]            irq_flag;     // interrupt flags
	logic [7:0]            wake_en;      // wake enables
	pic_pin_cfg_t [7:0]    sense_cfg;    // per pin config
	pic_sync_t             sync_state;   // control sync state
	logic [1:0]            sync_cnt;     // sync cycles left
	logic                  pend_en;      // enable value in flight
	logic                  pend_rst;     // soft reset in flight
	logic                  soft_rst;     // applies soft reset

	// ------------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------------
	logic       acc;        // access phase present
	logic       done;       // transfer completes this edge
	logic       wr;         // write completes this edge
	logic [7:0] idx;        // register index
	logic       mapped;     // index decodes
	logic       is_flag;    // unprotected flag register
	logic       blocked;    // protected write refused
	logic       wr_ok;      // write takes effect
	logic       ctrl_stall; // control write while busy
	logic       sync_busy;  // sync in progress

	assign acc        = psel_i & penable_i;
	assign done       = acc & pready_o;
	assign idx        = paddr_i[9:2];
	assign mapped     = (paddr_i[31:10] == 22'h00_0000) && (idx <= `PIC_IDX_SENSE);
	assign is_flag    = (idx == `PIC_IDX_NMI_FLAG_REG) || (idx == `PIC_IDX_IRQFLAG);
	// debugger writes pass the lock; flag registers never locked
	assign blocked    = wr_protect_i & ~dbg_access_i & ~is_flag;
	assign wr         = done & pwrite_i;
	assign wr_ok      = wr & mapped & ~blocked;
	assign sync_busy  = (sync_state == PIC_SYNC_RUN);
	// a second control write waits for the running sync
	assign ctrl_stall = pwrite_i & (idx == `PIC_IDX_CTRL) & sync_busy;

	// ------------------------------------------------------------------------
	// apb response: one wait state, ready and data from flops
	// ------------------------------------------------------------------------
	// a stalled control write keeps ready low until busy clears
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= acc & ~pready_o & ~ctrl_stall;
			pslverr_o <= acc & ~pready_o & ~ctrl_stall & (~mapped | (pwrite_i & blocked));
		end
	end

	// read mux registered alongside ready
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (acc & ~pready_o & ~pwrite_i) begin
			unique case (idx)
				`PIC_IDX_CTRL:     prdata_o <= {30'h0, enable, 1'b0};
				`PIC_IDX_STATUS:   prdata_o <= {24'h0, sync_busy, 7'h00};
				`PIC_IDX_NMICFG:   prdata_o <= {28'h0, nmi_filt, nmi_sense};
				`PIC_IDX_NMI_FLAG_REG:  prdata_o <= {31'h0, nmi_flag};
				`PIC_IDX_EVOUT:    prdata_o <= {24'h0, event_out};
				`PIC_IDX_INTENCLR: prdata_o <= {24'h0, irq_en};
				`PIC_IDX_INTENSET: prdata_o <= {24'h0, irq_en};
				`PIC_IDX_IRQFLAG:  prdata_o <= {24'h0, irq_flag};
				`PIC_IDX_WAKE:     prdata_o <= {24'h0, wake_en};
				`PIC_IDX_SENSE:    prdata_o <= sense_cfg;
				default:           prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// control sync: enable and soft reset pass a fixed delay
	// ------------------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			sync_state <= PIC_SYNC_IDLE;
			sync_cnt   <= 2'h0;
			pend_en    <= 1'b0;
			pend_rst   <= 1'b0;
		end else begin
			unique case (sync_state)
				PIC_SYNC_IDLE: begin
					if (wr_ok && idx == `PIC_IDX_CTRL) begin
						sync_state <= PIC_SYNC_RUN;
						sync_cnt   <= `PIC_SYNC_CYC;
						pend_en    <= pwdata_i[`PIC_CTRL_ENABLE];
						pend_rst   <= pwdata_i[`PIC_CTRL_SOFT_RESET_BIT];
					end
				end
				PIC_SYNC_RUN: begin
					sync_cnt <= sync_cnt - 2'h1;
					if (sync_cnt == 2'h1) begin
						sync_state <= PIC_SYNC_IDLE;
					end
				end
			endcase
		end
	end

	// soft reset fires as the sync completes
	assign soft_rst = sync_busy & (sync_cnt == 2'h1) & pend_rst;

	// enable follows the synced value
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			enable <= 1'b0;
		end else if (sync_busy && sync_cnt == 2'h1) begin
			enable <= pend_en;
		end
	end

	// ------------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------------
	// flags are not here: hardware sets them further down
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			nmi_sense <= 3'h0;
			nmi_filt  <= 1'b0;
			event_out <= `PIC_RST_BYTE;
			irq_en    <= `PIC_RST_BYTE;
			wake_en   <= `PIC_RST_BYTE;
			sense_cfg <= `PIC_RST_SENSE;
		end else if (wr_ok) begin
			unique case (idx)
				`PIC_IDX_NMICFG: begin
					nmi_sense <= pwdata_i[2:0];
					nmi_filt  <= pwdata_i[`PIC_NMI_FILT];
				end
				`PIC_IDX_EVOUT:    event_out <= pwdata_i[7:0];
				`PIC_IDX_INTENCLR: irq_en    <= irq_en & ~pwdata_i[7:0];
				`PIC_IDX_INTENSET: irq_en    <= irq_en | pwdata_i[7:0];
				`PIC_IDX_WAKE:     wake_en   <= pwdata_i[7:0];
				`PIC_IDX_SENSE:    sense_cfg <= pwdata_i;
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// detection function shared by all nine inputs
	// ------------------------------------------------------------------------
	function automatic logic pic_hit(input logic [2:0] s, input logic cur, input logic prv);
		logic h;
		h = 1'b0;
		unique case (s)
			PIC_SENSE_RISE: h = cur & ~prv;
			PIC_SENSE_FALL: h = ~cur & prv;
			PIC_SENSE_BOTH: h = cur ^ prv;
			PIC_SENSE_HIGH: h = cur;
			PIC_SENSE_LOW:  h = ~cur;
			default:        h = 1'b0;
		endcase
		return h;
	endfunction : pic_hit

	// ------------------------------------------------------------------------
	// per pin filter and detection, inputs 0..7 external, 8 nmi
	// ------------------------------------------------------------------------
	logic [8:0] pins;      // raw pin levels
	logic [8:0] hit;       // condition met this cycle
	logic [8:0] hit_prev;  // condition last cycle
	logic [8:0] filt_on;   // filter selected
	logic [8:0] runs;      // detection active
	logic [2:0] sense [9]; // sense per input

	assign pins = {nmi_i, ext_irq_input_i};

	generate
		for (genvar g = 0; g < 9; g++) begin : g_pin
			logic [2:0] smp;  // three-sample window
			logic       maj;  // majority vote
			logic       cur;  // filtered or raw sample
			logic       prv;  // previous sample

			if (g < 8) begin : g_ext
				assign sense[g]   = sense_cfg[g].sense;
				assign filt_on[g] = sense_cfg[g].filt_en;
				assign runs[g]    = enable;
			end else begin : g_nmi
				assign sense[g]   = nmi_sense;
				assign filt_on[g] = nmi_filt;
				assign runs[g]    = 1'b1; // nmi works without enable
			end

			// sample shift and previous value
			always_ff @(posedge ref_clk_i) begin
				if (sys_rst_i || soft_rst) begin
					smp <= 3'h0;
					prv <= 1'b0;
				end else begin
					smp <= {smp[1:0], pins[g]};
					prv <= cur;
				end
			end

			// two of three samples decide the filtered level
			assign maj    = (smp[0] & smp[1]) | (smp[1] & smp[2]) | (smp[0] & smp[2]);
			assign cur    = filt_on[g] ? maj : pins[g];
			assign hit[g] = runs[g] & pic_hit(sense[g], cur, prv);
		end
	endgenerate

	// condition one cycle ago, so events fire only on its rise
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			hit_prev <= 9'h000;
		end else begin
			hit_prev <= hit;
		end
	end

	// ------------------------------------------------------------------------
	// flags: set beats a same-cycle clear; level keeps re-flagging
	// ------------------------------------------------------------------------
	logic [7:0] irq_clr; // flag clear mask
	logic       nmi_clr; // nmi clear

	// write one clears; zero bits leave their flag alone
	assign irq_clr = (wr_ok && idx == `PIC_IDX_IRQFLAG) ? pwdata_i[7:0] : 8'h00;
	assign nmi_clr = wr_ok && (idx == `PIC_IDX_NMI_FLAG_REG) && pwdata_i[0];

	// debug halt has no input here, so nothing pauses detection
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_rst) begin
			irq_flag <= 8'h00;
			nmi_flag <= 1'b0;
		end else begin
			irq_flag <= (irq_flag & ~irq_clr) | hit[7:0];
			nmi_flag <= (nmi_flag & ~nmi_clr) | hit[8];
		end
	end

	// ------------------------------------------------------------------------
	// outputs from flops
	// ------------------------------------------------------------------------
	// registered so that every output leaves a flop
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			irq_o     <= 1'b0;
			nmi_req_o <= 1'b0;
			event_o   <= 8'h00;
			wake_o    <= 1'b0;
		end else begin
			irq_o     <= |(irq_flag & irq_en);
			nmi_req_o <= nmi_flag;
			event_o   <= hit[7:0] & ~hit_prev[7:0] & event_out;
			wake_o    <= |(hit[7:0] & wake_en);
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	// request outputs
	a_irq_masked: assert property (irq_o |-> $past(|(irq_flag & irq_en)))
		else $error("shared request without enabled flag");
	a_nmi_follows: assert property (nmi_flag |=> nmi_req_o)
		else $error("nmi request missing");
	a_event_pulse: assert property (event_o[0] |=> !event_o[0])
		else $error("event longer than one cycle");
	a_wake_mask: assert property (wake_en == 8'h00 |=> !wake_o)
		else $error("wake raised with no wake enable");

	// control sync: the synced value lands on the third edge after the write,
	// so it is first seen at the fourth sampling edge
	a_busy_len: assert property ($rose(sync_busy) |-> sync_busy [*3] ##1 !sync_busy)
		else $error("sync busy length wrong");
	a_sync_start: assert property (wr_ok && idx == `PIC_IDX_CTRL && !soft_rst |=> sync_busy)
		else $error("busy bit not set at once");
	a_en_set: assert property (wr_ok && idx == `PIC_IDX_CTRL && !sync_busy
		&& pwdata_i[1] && !pwdata_i[0] |-> ##4 enable)
		else $error("enable not applied");
	a_en_clr: assert property (wr_ok && idx == `PIC_IDX_CTRL && !sync_busy
		&& !pwdata_i[1] |-> ##4 !enable)
		else $error("disable not applied");
	a_soft_reset: assert property (soft_rst |=> irq_en == 8'h00 && !enable
		&& nmi_sense == 3'h0)
		else $error("soft reset incomplete");
	a_stall: assert property (acc && ctrl_stall |=> !pready_o)
		else $error("busy control write not stalled");

	// write protection: the lock holds unless the debugger writes
	a_protect: assert property (wr && wr_protect_i && !dbg_access_i && !soft_rst
		&& idx == `PIC_IDX_WAKE |=> $stable(wake_en))
		else $error("protected write took effect");
	a_nmi_protect: assert property (wr && wr_protect_i && !dbg_access_i && !soft_rst
		&& idx == `PIC_IDX_NMICFG |=> $stable(nmi_sense) && $stable(nmi_filt))
		else $error("protected nmi config changed");
	a_dbg_bypass: assert property (wr && mapped && wr_protect_i && dbg_access_i
		&& !soft_rst && idx == `PIC_IDX_NMICFG |=> nmi_sense == $past(pwdata_i[2:0]))
		else $error("debugger write refused");

	// detection and flags
	a_ext_gated: assert property (!enable |-> hit[7:0] == 8'h00)
		else $error("disabled controller detected a pin");
	a_nmi_quiet: assert property (nmi_sense == 3'h0 |-> !hit[8])
		else $error("nmi detected with no sense");
	a_set_wins: assert property (hit[3] && irq_clr[3] && !soft_rst |=> irq_flag[3])
		else $error("flag lost on clear");
	a_majority: assert property (filt_on[2] && sense[2] == 3'h1 && enable && !soft_rst
		&& !g_pin[2].prv && g_pin[2].smp == 3'b011 |=> irq_flag[2])
		else $error("vote of two ones missed");

	// main scenarios reached
	c_nmi: cover property (nmi_req_o);
	c_event: cover property (event_o != 8'h00);
	c_wake: cover property (wake_o);
	c_stall: cover property (acc && ctrl_stall);
	c_vote: cover property (filt_on[2] && g_pin[2].maj);

endmodule : pic_pin_irq_controller

// >>> dv/pic_far_model.sv
// ----------------------------------------------------------------------------
// event routing side: counts event pulses and the extra high cycles of pulses held too long
// ----------------------------------------------------------------------------
module pic_far_model (
	input  wire logic       ref_clk_i,  // system clock
	input  wire logic       sys_rst_i,  // synchronous reset, high
	input  wire logic [7:0] event_i,    // event lines from the controller
	output logic      [7:0] ev_total_o, // count of event pulse starts
	output logic      [7:0] ev_long_o   // count of cycles an event stayed high
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] ev_q; // event lines one cycle ago

	// a pulse is one cycle high; a second high cycle means a held level
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ev_q       <= 8'h00;
			ev_total_o <= 8'h00;
			ev_long_o  <= 8'h00;
		end else begin
			ev_q       <= event_i;
			ev_total_o <= ev_total_o + 8'($countones(event_i & ~ev_q));
			ev_long_o  <= ev_long_o + 8'($countones(event_i & ev_q));
		end
	end
endmodule : pic_far_model

// >>> dv/external_pin_interrupt_ctrl_tb_top.sv
`include "pic_params.svh"
module external_pin_interrupt_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        ref_clk_i = 1'b0; // bench clock
	logic        sys_rst_i = 1'b1; // bench reset
	logic        psel      = 1'b0; // apb select
	logic        penable   = 1'b0; // apb enable
	logic        pwrite    = 1'b0; // apb direction
	logic [31:0] paddr     = '0;   // apb address
	logic [31:0] pwdata    = '0;   // apb write data
	logic        prot      = 1'b0; // protector lock
	logic        dbg       = 1'b0; // debugger access
	logic        nmi       = 1'b0; // nmi pin
	logic [7:0]  ext       = '0;   // external pins
	logic [31:0] prdata, rd;       // read data, last read
	logic        pready, pslverr, err, irq, nmi_req, wake; // dut outputs
	logic [7:0]  evt, ev_total, ev_long; // events and model counts
	int          mismatches = 0, checked = 0, n; // counters, wait cycles

	always #50 ref_clk_i = ~ref_clk_i;

	pic_pin_irq_controller dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.wr_protect_i(prot), .dbg_access_i(dbg), .ext_irq_input_i(ext), .nmi_i(nmi),
		.irq_o(irq), .nmi_req_o(nmi_req), .event_o(evt), .wake_o(wake));
	pic_far_model far_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .event_i(evt),
		.ev_total_o(ev_total), .ev_long_o(ev_long));

	// ------------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; n counts edges spent waiting for ready
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		n = 0;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdc

	// control write, then wait out the sync busy bit
	task ctl(input logic [31:0] v);
		apb(1'b1, `PIC_IDX_CTRL, v);
		do apb(1'b0, `PIC_IDX_STATUS, 32'h0000_0000); while (rd[`PIC_STAT_BUSY] !== 1'b0);
	endtask : ctl

	task wt(input int k);
		repeat (k) @(posedge ref_clk_i);
	endtask : wt

	task complete_run;
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------------
	task t_regs;
		for (int i = 0; i < 10; i++) rdc(8'(i), 32'h0000_0000);
		apb(1'b0, 8'h0a, 32'h0000_0000);
		chk(err, 1'b1);
		$display("test regs done");
	endtask : t_regs

	// sense codes 1 to 5 on pin 3: flag after a fall, then after a clear
	task t_sense;
		logic [5:0] after_fall, after_clr; // expected per sense code
		after_fall = 6'b11_1100;
		after_clr = 6'b10_0000;
		ext[3] <= 1'b1;
		apb(1'b1, `PIC_IDX_EVOUT, 32'h0000_0008);
		apb(1'b1, `PIC_IDX_INTENSET, 32'h0000_0008);
		ctl(32'h0000_0002);
		for (int s = 1; s < 6; s++) begin
			apb(1'b1, `PIC_IDX_SENSE, 32'(s) << 12);
			wt(4);
			apb(1'b1, `PIC_IDX_IRQFLAG, 32'h0000_0008);
			ext[3] <= 1'b0;
			wt(4);
			rdc(`PIC_IDX_IRQFLAG, {28'h0, after_fall[s], 3'h0});
			chk(irq, after_fall[s]);
			apb(1'b1, `PIC_IDX_IRQFLAG, 32'h0000_0008);
			wt(4);
			rdc(`PIC_IDX_IRQFLAG, {28'h0, after_clr[s], 3'h0});
			ext[3] <= 1'b1;
			wt(4);
		end
		chk(ev_long, 8'h00);
		chk(ev_total != 8'h00, 1'b1);
		ext[3] <= 1'b0;
		wt(4);
		apb(1'b1, `PIC_IDX_INTENCLR, 32'h0000_0008);
		wt(3);
		chk(irq, 1'b0);
		rdc(`PIC_IDX_IRQFLAG, 32'h0000_0008);
		apb(1'b1, `PIC_IDX_WAKE, 32'h0000_0008);
		wt(3);
		chk(wake, 1'b1);
		apb(1'b1, `PIC_IDX_WAKE, 32'h0000_0000);
		wt(3);
		chk(wake, 1'b0);
		ctl(32'h0000_0000);
		apb(1'b1, `PIC_IDX_IRQFLAG, 32'h0000_0008);
		wt(4);
		rdc(`PIC_IDX_IRQFLAG, 32'h0000_0000);
		$display("test sense done");
	endtask : t_sense

	// one-cycle spike on pin 2, with and without the vote filter
	task t_filt;
		// sense first, so pins left low from the last scenario cannot flag
		apb(1'b1, `PIC_IDX_SENSE, 32'h0000_0900);
		ctl(32'h0000_0002);
		wt(4);
		apb(1'b1, `PIC_IDX_IRQFLAG, 32'h0000_0004);
		ext[2] <= 1'b1;
		wt(1);
		ext[2] <= 1'b0;
		wt(6);
		rdc(`PIC_IDX_IRQFLAG, 32'h0000_0000);
		ext[2] <= 1'b1;
		wt(6);
		rdc(`PIC_IDX_IRQFLAG, 32'h0000_0004);
		apb(1'b1, `PIC_IDX_SENSE, 32'h0000_0100);
		ext[2] <= 1'b0;
		wt(3);
		apb(1'b1, `PIC_IDX_IRQFLAG, 32'h0000_0004);
		ext[2] <= 1'b1;
		wt(1);
		ext[2] <= 1'b0;
		wt(4);
		rdc(`PIC_IDX_IRQFLAG, 32'h0000_0004);
		$display("test filter done");
	endtask : t_filt

	// nmi config is written before the nmi pin is raised
	task t_nmi;
		prot <= 1'b1;
		apb(1'b1, `PIC_IDX_NMICFG, 32'h0000_0001);
		chk(err, 1'b1);
		rdc(`PIC_IDX_NMICFG, 32'h0000_0000);
		apb(1'b1, `PIC_IDX_WAKE, 32'h0000_00ff);
		chk(err, 1'b1);
		rdc(`PIC_IDX_WAKE, 32'h0000_0000);
		dbg <= 1'b1;
		apb(1'b1, `PIC_IDX_NMICFG, 32'h0000_0001);
		chk(err, 1'b0);
		dbg <= 1'b0;
		nmi <= 1'b1;
		wt(4);
		rdc(`PIC_IDX_NMI_FLAG_REG, 32'h0000_0001);
		chk(nmi_req, 1'b1);
		apb(1'b1, `PIC_IDX_NMI_FLAG_REG, 32'h0000_0001);
		chk(err, 1'b0);
		wt(2);
		chk(nmi_req, 1'b0);
		prot <= 1'b0;
		$display("test nmi done");
	endtask : t_nmi

	task t_soft_reset_bit;
		apb(1'b1, `PIC_IDX_WAKE, 32'h0000_00ff);
		apb(1'b1, `PIC_IDX_SENSE, 32'h1111_1111);
		apb(1'b1, `PIC_IDX_CTRL, 32'h0000_0002);
		apb(1'b1, `PIC_IDX_CTRL, 32'h0000_0001);
		chk(n > 2, 1'b1);
		ctl(32'h0000_0000);
		for (int i = 0; i < 10; i++) rdc(8'(i), 32'h0000_0000);
		$display("test soft reset done");
	endtask : t_soft_reset_bit

	// ------------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_regs;
		t_sense;
		t_filt;
		t_nmi;
		t_soft_reset_bit;
		complete_run;
	end

	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		complete_run;
	end
endmodule : external_pin_interrupt_ctrl_tb_top
